// ### switch_spi_pkg.sv
package switch_spi_pkg;

  localparam int WORD_W = 16;
  localparam int DATA_W = 12;
  localparam int NUM_HS = 4;
  localparam int CNT_W  = 4;

  // Command word fields
  localparam int ADDR_LSB = 12;
  localparam int ADDR_MSB = 14;
  localparam int WD_BIT   = 15;
  localparam int WDT_LSB  = 4;
  localparam int WDT_MSB  = 5;

  // Address field read as word[14:12]; D12 is the first letter of a pattern
  localparam logic [2:0] ADDR_OUT_CTL  = 3'h0;
  localparam logic [2:0] ADDR_DIR_EN   = 3'h4;
  localparam logic [2:0] ADDR_LOGIC_FN = 3'h2;
  localparam logic [2:0] ADDR_WD_CFG   = 3'h6;

  // Reset values
  localparam logic [DATA_W-1:0] CFG_RST  = 12'h000;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [1:0]        WDT_RST  = 2'h0;
  localparam logic [CNT_W-1:0]  CNT_RST  = 4'h0;
  localparam logic [CNT_W-1:0]  CNT_LAST = 4'hF;

  // Positions in the synchronised input bundle
  localparam int SYN_SCLK  = 0;
  localparam int SYN_SI    = 1;
  localparam int SYN_SEL   = 2;
  localparam int SYN_LS    = 3;
  localparam int SYN_FSI   = 4;
  localparam int SYN_WAKE  = 5;
  localparam int SYN_HS    = 6;
  localparam int SYN_FLT   = 10;
  localparam int SYN_W     = 22;

  // Select idles high, so its synchroniser resets high
  localparam logic [SYN_W-1:0] SYN_RST = 22'h000004;

endpackage

// ### input_sync.sv
module input_sync #(
  parameter int                   W       = 1,
  parameter logic [W-1:0]         RST_VAL = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_r   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ### output_combine.sv
module output_combine (
  input  wire logic [11:0] out_ctl,
  input  wire logic [11:0] dir_en_n,
  input  wire logic [11:0] logic_fn,
  input  wire logic [3:0]  hs_in,
  input  wire logic        ls_in,
  output logic      [11:0] out_nxt
);

  genvar i;
  generate
    for (i = 0; i < switch_spi_pkg::DATA_W; i++) begin : g_out
      wire src;
      wire mixed;
      if (i < switch_spi_pkg::NUM_HS) begin : g_hs
        assign src = hs_in[i];
      end else begin : g_ls
        assign src = ls_in;
      end
      // One selects AND, zero selects OR
      assign mixed = logic_fn[i] ? (src & out_ctl[i])
                                 : (src | out_ctl[i]);
      // Zero in the enable register hands the output to its pin
      assign out_nxt[i] = dir_en_n[i] ? out_ctl[i] : mixed;
    end
  endgenerate

endmodule

// ### switch_spi_command_port.sv
// Operation
// - Sample serial input on clock falling edge
// - Change serial output on clock rising edge
// - Select high: ignore clock, input; output off
// - Drive serial output only while select low
// - Sixteen-bit words, most significant bit first
// - Bits 0-11 data, 12-14 address, 15 watchdog
// - Select rising commits word to addressed register
// - Select falling loads status into output shifter
// - Commit only whole multiples of sixteen bits
// - Status bits 0-11 flag faulted outputs
// - Bits 12-14 show inputs chosen by echo
// - Control register drives high and low outputs
// - Zero bit puts output under pin control
// - One in low bits ANDs pin and control
// - Bit 15 is watchdog input, not data
// - Watchdog config bits 4,5 select timeout
// - Zero ORs pin and control; low side alike
// - Echo picks inputs 0,1,fail-safe or 2,3,wake
// - After sixteen status bits, echo received bits
// - Select rising re-arms fault capture
module switch_spi_command_port (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        sclk,
  input  wire logic        serial_in,
  input  wire logic        select_low,
  output logic             serial_out,
  output logic             serial_out_oe,
  input  wire logic [3:0]  high_side_direct_input,
  input  wire logic        low_side_direct_input,
  input  wire logic        fail_safe_input,
  input  wire logic        wake_input,
  input  wire logic [11:0] output_fault_in,
  output logic      [3:0]  high_side_outputs,
  output logic      [7:0]  low_side_outputs,
  output logic             watchdog_in_bit,
  output logic             watchdog_strobe,
  output logic      [1:0]  watchdog_timeout_sel,
  output logic             watchdog_echo_bit
);

  localparam int DW = switch_spi_pkg::DATA_W;
  localparam int WW = switch_spi_pkg::WORD_W;
  localparam int NH = switch_spi_pkg::NUM_HS;

  // Synchronised pins
  logic [switch_spi_pkg::SYN_W-1:0] raw_in;
  logic [switch_spi_pkg::SYN_W-1:0] syn;

  assign raw_in = {output_fault_in, high_side_direct_input, wake_input,
                   fail_safe_input, low_side_direct_input, select_low,
                   serial_in, sclk};

  input_sync #(
    .W       (switch_spi_pkg::SYN_W),
    .RST_VAL (switch_spi_pkg::SYN_RST)
  ) u_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (raw_in),
    .sync_out (syn)
  );

  wire          sclk_s  = syn[switch_spi_pkg::SYN_SCLK];
  wire          si_s    = syn[switch_spi_pkg::SYN_SI];
  wire          sel_s   = syn[switch_spi_pkg::SYN_SEL];
  wire          ls_s    = syn[switch_spi_pkg::SYN_LS];
  wire          fsi_s   = syn[switch_spi_pkg::SYN_FSI];
  wire          wake_s  = syn[switch_spi_pkg::SYN_WAKE];
  wire [NH-1:0] hs_s    = syn[switch_spi_pkg::SYN_HS +: NH];
  wire [DW-1:0] fault_s = syn[switch_spi_pkg::SYN_FLT +: DW];

  // Edge detection
  logic sclk_d_r;
  logic sel_d_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_d_r <= 1'b0;
      sel_d_r  <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      sel_d_r  <= sel_s;
    end
  end

  wire in_frame  = !sel_s && !sel_d_r;
  wire sel_fall  = !sel_s && sel_d_r;
  wire sel_rise  = sel_s && !sel_d_r;
  // Clock and data only count inside a frame
  wire sclk_fall = in_frame && !sclk_s && sclk_d_r;
  wire sclk_rise = in_frame && sclk_s && !sclk_d_r;

  // Shift registers and bit counter
  logic [WW-1:0]                    rx_sr_r;
  logic [WW-1:0]                    rx_sr_nxt;
  logic [WW-1:0]                    tx_sr_r;
  logic [WW-1:0]                    tx_sr_nxt;
  logic [WW-1:0]                    tx_fill_nxt;
  logic [switch_spi_pkg::CNT_W-1:0] bit_cnt_r;
  logic                             word_seen_r;
  logic                             oe_r;
  logic [DW-1:0]                    fault_lat_r;
  logic [WW-1:0]                    status_word;
  logic [2:0]                       pin_view;

  assign rx_sr_nxt = {rx_sr_r[WW-2:0], si_s};
  assign tx_sr_nxt   = {tx_sr_r[WW-2:0], 1'b0};
  // Received bit drops into the stage a rise just vacated, so the
  // first one follows status bit 0 with no spare stage in between
  assign tx_fill_nxt = {tx_sr_r[WW-1:1], si_s};

  // Echo picks which three pins are reported
  assign pin_view = watchdog_echo_bit ? {hs_s[2], hs_s[3], wake_s}
                                      : {hs_s[0], hs_s[1], fsi_s};
  assign status_word = {watchdog_echo_bit, pin_view,
                        fault_lat_r | fault_s};

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_sr_r <= switch_spi_pkg::WORD_RST;
    end else if (sclk_fall) begin
      rx_sr_r <= rx_sr_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tx_sr_r <= switch_spi_pkg::WORD_RST;
    end else if (sel_fall) begin
      tx_sr_r <= status_word;
    end else if (sclk_rise) begin
      tx_sr_r <= tx_sr_nxt;
    end else if (sclk_fall) begin
      tx_sr_r <= tx_fill_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bit_cnt_r   <= switch_spi_pkg::CNT_RST;
      word_seen_r <= 1'b0;
    end else if (sel_fall) begin
      bit_cnt_r   <= switch_spi_pkg::CNT_RST;
      word_seen_r <= 1'b0;
    end else if (sclk_fall) begin
      bit_cnt_r <= bit_cnt_r + 1'b1;
      if (bit_cnt_r == switch_spi_pkg::CNT_LAST) begin
        word_seen_r <= 1'b1;
      end
    end
  end

  // Output driver enabled only during the frame
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      oe_r <= 1'b0;
    end else if (sel_fall) begin
      oe_r <= 1'b1;
    end else if (sel_rise) begin
      oe_r <= 1'b0;
    end
  end

  assign serial_out    = tx_sr_r[WW-1];
  assign serial_out_oe = oe_r;

  // Faults stay sticky until the frame ends; a new fault beats the clear
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fault_lat_r <= switch_spi_pkg::CFG_RST;
    end else if (sel_rise) begin
      fault_lat_r <= fault_s;
    end else begin
      fault_lat_r <= fault_lat_r | fault_s;
    end
  end

  // Commit decode
  wire       word_ok  = word_seen_r &&
                        (bit_cnt_r == switch_spi_pkg::CNT_RST);
  wire       commit   = sel_rise && word_ok;
  wire [2:0] addr     = rx_sr_r[switch_spi_pkg::ADDR_MSB:
                                switch_spi_pkg::ADDR_LSB];
  wire [DW-1:0] data  = rx_sr_r[DW-1:0];
  wire       wd_bit   = rx_sr_r[switch_spi_pkg::WD_BIT];
  wire       wr_ctl   = commit && (addr == switch_spi_pkg::ADDR_OUT_CTL);
  wire       wr_den   = commit && (addr == switch_spi_pkg::ADDR_DIR_EN);
  wire       wr_lfn   = commit && (addr == switch_spi_pkg::ADDR_LOGIC_FN);
  wire       wr_wdc   = commit && (addr == switch_spi_pkg::ADDR_WD_CFG);

  logic [DW-1:0] output_on_off_control_r;
  logic [DW-1:0] direct_control_enable_r;
  logic [DW-1:0] direct_logic_function_r;
  logic [DW-1:0] out_nxt;
  logic          strobe_r;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      output_on_off_control_r <= switch_spi_pkg::CFG_RST;
      direct_control_enable_r <= switch_spi_pkg::CFG_RST;
      direct_logic_function_r <= switch_spi_pkg::CFG_RST;
    end else begin
      if (wr_ctl) begin
        output_on_off_control_r <= data;
      end
      if (wr_den) begin
        direct_control_enable_r <= data;
      end
      if (wr_lfn) begin
        direct_logic_function_r <= data;
      end
    end
  end

  // Watchdog bit travels with every whole word, but only the
  // control register write sets the echo seen in the status word
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_in_bit      <= 1'b0;
      strobe_r             <= 1'b0;
      watchdog_timeout_sel <= switch_spi_pkg::WDT_RST;
      watchdog_echo_bit    <= 1'b0;
    end else begin
      strobe_r <= commit;
      if (commit) begin
        watchdog_in_bit <= wd_bit;
      end
      if (wr_ctl) begin
        watchdog_echo_bit <= wd_bit;
      end
      if (wr_wdc) begin
        watchdog_timeout_sel <=
          {rx_sr_r[switch_spi_pkg::WDT_MSB],
           rx_sr_r[switch_spi_pkg::WDT_LSB]};
      end
    end
  end

  assign watchdog_strobe = strobe_r;

  output_combine u_comb (
    .out_ctl  (output_on_off_control_r),
    .dir_en_n (direct_control_enable_r),
    .logic_fn (direct_logic_function_r),
    .hs_in    (hs_s),
    .ls_in    (ls_s),
    .out_nxt  (out_nxt)
  );

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      high_side_outputs <= '0;
      low_side_outputs  <= '0;
    end else begin
      high_side_outputs <= out_nxt[NH-1:0];
      low_side_outputs  <= out_nxt[DW-1:NH];
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  chk_oe_on_fall: assert property (
    sel_fall |=> serial_out_oe && serial_out == $past(status_word[WW-1]))
    else $error("serial output not enabled with status at select fall");

  chk_oe_off_rise: assert property (
    sel_rise |=> !serial_out_oe)
    else $error("serial output still driven after select rise");

  chk_oe_idle_off: assert property (
    sel_s && sel_d_r |-> !serial_out_oe)
    else $error("serial output driven while select high");

  chk_status_load: assert property (
    sel_fall |=> tx_sr_r == $past(status_word))
    else $error("status word not loaded at select fall");

  chk_rx_sample: assert property (
    sclk_fall |=> rx_sr_r == {$past(rx_sr_r[WW-2:0]), $past(si_s)}
      && tx_sr_r[0] == $past(si_s))
    else $error("serial input not shifted on clock fall");

  chk_tx_shift: assert property (
    sclk_rise |=> tx_sr_r == {$past(tx_sr_r[WW-2:0]), 1'b0})
    else $error("serial output not shifted on clock rise");

  chk_idle_ignore: assert property (
    sel_s && sel_d_r |=> $stable(rx_sr_r) && $stable(bit_cnt_r))
    else $error("activity taken while select high");

  chk_commit_ctl: assert property (
    wr_ctl |=> output_on_off_control_r == $past(data)
               && watchdog_echo_bit == $past(wd_bit))
    else $error("control word not committed at select rise");

  chk_bad_length: assert property (
    sel_rise && !word_ok |=> $stable(output_on_off_control_r)
      && $stable(direct_control_enable_r)
      && $stable(direct_logic_function_r)
      && $stable(watchdog_timeout_sel) && !watchdog_strobe)
    else $error("register changed by frame of wrong length");

  chk_wd_cfg: assert property (
    wr_wdc |=> watchdog_timeout_sel ==
      $past({rx_sr_r[switch_spi_pkg::WDT_MSB],
             rx_sr_r[switch_spi_pkg::WDT_LSB]}))
    else $error("watchdog timeout select not taken from bits 5 and 4");

  chk_fault_rearm: assert property (
    sel_rise |=> fault_lat_r == $past(fault_s))
    else $error("fault capture not re-armed at select rise");

  chk_out_follow: assert property (
    1'b1 |=> {low_side_outputs, high_side_outputs} == $past(out_nxt))
    else $error("outputs do not follow combined control");

  chk_oe_in_frame: assert property (
    in_frame |-> serial_out_oe)
    else $error("serial output released inside a frame");

  chk_strobe_commit: assert property (
    commit |=> watchdog_strobe && watchdog_in_bit == $past(wd_bit))
    else $error("watchdog bit not passed on with whole word");

  chk_view_low: assert property (
    sel_fall && !watchdog_echo_bit |=> tx_sr_r[WW-2] == $past(hs_s[0])
      && tx_sr_r[WW-3] == $past(hs_s[1]) && tx_sr_r[WW-4] == $past(fsi_s))
    else $error("status pins wrong with echo bit low");

  chk_view_high: assert property (
    sel_fall && watchdog_echo_bit |=> tx_sr_r[WW-2] == $past(hs_s[2])
      && tx_sr_r[WW-3] == $past(hs_s[3]) && tx_sr_r[WW-4] == $past(wake_s))
    else $error("status pins wrong with echo bit high");

  chk_commit_den: assert property (
    wr_den |=> direct_control_enable_r == $past(data))
    else $error("direct enable word not committed");

  chk_commit_lfn: assert property (
    wr_lfn |=> direct_logic_function_r == $past(data))
    else $error("logic function word not committed");

endmodule

// ### spi_master_model.sv
module spi_master_model (
  input  wire logic sys_clk,
  input  wire logic so_wire,
  output logic      sclk,
  output logic      serial_in,
  output logic      select_low
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle: select pulled high, clock and data pulled low
  initial begin
    sclk       = 1'b0;
    serial_in  = 1'b0;
    select_low = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Status is taken just before each rise, where it has stood longest
  task automatic xfer(input int nbits, input logic [47:0] din,
                      output logic [47:0] dout);
    dout = '0;
    select_low = 1'b0;
    wait_clk(6);
    for (int i = nbits - 1; i >= 0; i--) begin
      dout[i]   = so_wire;
      sclk      = 1'b1;
      serial_in = din[i];
      wait_clk(4);
      sclk = 1'b0;
      wait_clk(4);
    end
    wait_clk(2);
    select_low = 1'b1;
    serial_in  = 1'b0;
    wait_clk(8);
  endtask

  // Clock and data activity with select high, which must be ignored
  task automatic noise();
    repeat (3) begin
      sclk      = 1'b1;
      serial_in = 1'b1;
      wait_clk(4);
      sclk      = 1'b0;
      serial_in = 1'b0;
      wait_clk(4);
    end
  endtask
endmodule

// ### testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk;
  logic        resetn;
  wire logic   sclk;
  wire logic   serial_in;
  wire logic   select_low;
  logic        serial_out;
  logic        serial_out_oe;
  wire logic   so_wire;
  logic [3:0]  hs_pin;
  logic        ls_pin;
  logic        fsi_pin;
  logic        wake_pin;
  logic [11:0] fault_pin;
  logic [3:0]  high_side_outputs;
  logic [7:0]  low_side_outputs;
  logic        watchdog_in_bit;
  logic        watchdog_strobe;
  logic [1:0]  watchdog_timeout_sel;
  logic        watchdog_echo_bit;
  logic [47:0] d;
  int          fail_count;
  int          tests_run;
  int          strobe_count;

  // No pull on the data out pin, so a released line reads as high impedance (z)
  assign so_wire = serial_out_oe ? serial_out : 1'bz;

  switch_spi_command_port switch_spi_command_port_inst (
    .sys_clk                (sys_clk),
    .resetn                 (resetn),
    .sclk                   (sclk),
    .serial_in              (serial_in),
    .select_low             (select_low),
    .serial_out             (serial_out),
    .serial_out_oe          (serial_out_oe),
    .high_side_direct_input (hs_pin),
    .low_side_direct_input  (ls_pin),
    .fail_safe_input        (fsi_pin),
    .wake_input             (wake_pin),
    .output_fault_in        (fault_pin),
    .high_side_outputs      (high_side_outputs),
    .low_side_outputs       (low_side_outputs),
    .watchdog_in_bit        (watchdog_in_bit),
    .watchdog_strobe        (watchdog_strobe),
    .watchdog_timeout_sel   (watchdog_timeout_sel),
    .watchdog_echo_bit      (watchdog_echo_bit)
  );

  spi_master_model spi_master_model_inst (
    .sys_clk    (sys_clk),
    .so_wire    (so_wire),
    .sclk       (sclk),
    .serial_in  (serial_in),
    .select_low (select_low)
  );

  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (watchdog_strobe === 1'b1) begin
      strobe_count++;
    end
  end

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run is about 1030 clocks; this allows ample slack
  initial begin
    #100us;
    fail_count++;
    close_out();
  end

  initial begin
    fail_count   = 0;
    tests_run    = 0;
    strobe_count = 0;
    resetn       = 1'b0;
    hs_pin       = 4'h0;
    ls_pin       = 1'b0;
    fsi_pin      = 1'b0;
    wake_pin     = 1'b0;
    fault_pin    = 12'h000;
    repeat (2) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    check({high_side_outputs, low_side_outputs, watchdog_echo_bit,
           watchdog_in_bit, watchdog_timeout_sel, serial_out_oe},
          48'h0);
    spi_master_model_inst.xfer(16, 48'h8ABC, d);
    check(d[15:0], 16'h0000);
    check({high_side_outputs, low_side_outputs, watchdog_echo_bit,
           watchdog_in_bit}, {4'hC, 8'hAB, 2'b11});
    spi_master_model_inst.noise();
    check({high_side_outputs, low_side_outputs, serial_out_oe},
          {4'hC, 8'hAB, 1'b0});
    @(negedge sys_clk);
    hs_pin    = 4'h6;
    ls_pin    = 1'b1;
    fsi_pin   = 1'b1;
    fault_pin = 12'h5A3;
    // First word would be a control write; only the last word counts
    spi_master_model_inst.xfer(32, {16'h0123, 16'h4FF0}, d);
    check(d[31:0], {16'hC5A3, 16'h0123});
    check({high_side_outputs, low_side_outputs, watchdog_echo_bit},
          {4'hE, 8'hAB, 1'b1});
    @(negedge sys_clk);
    fault_pin = 12'h000;
    spi_master_model_inst.xfer(16, 48'h200F, d);
    check(high_side_outputs, 4'h4);
    spi_master_model_inst.xfer(17, {1'b1, 16'h8FFF}, d);
    check({high_side_outputs, low_side_outputs, watchdog_in_bit},
          {4'h4, 8'hAB, 1'b0});
    spi_master_model_inst.xfer(16, 48'h000C, d);
    check(d[15:0], 16'hC000);
    spi_master_model_inst.xfer(16, 48'h6010, d);
    check(d[15:0], 16'h3000);
    check(watchdog_timeout_sel, 2'h1);
    check(48'(strobe_count), 48'd5);
    close_out();
  end
endmodule
